// file: rtl/tsm_pkg.sv
// time-slot switch memory access timing: constants, types and helpers
// assumes 8 reference clock periods per slot, 32 slots per 125 us frame
package tsm_pkg;

   localparam int CLK_PERIOD_NS = 10;
   localparam int FRAME_TIME_NS = 125000;
   localparam int SLOTS         = 32;
   localparam int PERIODS       = 8;
   localparam int LINES         = 4;
   // longest reference period that fits, so rounded down
   localparam int RCL_DIV       = FRAME_TIME_NS / (CLK_PERIOD_NS * SLOTS * PERIODS);
   localparam logic [5:0] RCL_DIV_LAST = 6'(RCL_DIV - 1);
   localparam int MF_DEPTH      = 16;

   // reference clock periods granted to each port access
   localparam logic [2:0] PCM_PER_A = 3'h0;
   localparam logic [2:0] PCM_PER_B = 3'h4;
   localparam logic [2:0] PCM_PER_C = 3'h7;
   localparam logic [2:0] CFI_WR_A  = 3'h1;
   localparam logic [2:0] CFI_WR_B  = 3'h3;
   localparam logic [2:0] CFI_RD_A  = 3'h5;
   localparam logic [2:0] CFI_RD_B  = 3'h6;
   localparam logic [2:0] LAST_PER  = 3'h7;

   localparam logic [4:0] CFI_AHEAD    = 5'h03;
   localparam logic [4:0] PCM_AHEAD_M0 = 5'h04;
   localparam logic [4:0] PCM_AHEAD_M1 = 5'h07;
   localparam logic [4:0] PCM_AHEAD_M2 = 5'h0d;
   localparam logic [3:0] FETCH_DONE   = 4'h8;
   localparam logic [2:0] PUSH_DONE    = 3'h4;

   localparam logic [3:0] CM_UNASSIGNED = 4'h0;
   localparam logic [3:0] CM_SWITCH     = 4'h1;
   localparam logic [3:0] CM_CS         = 4'h8;
   localparam logic [3:0] CM_MF         = 4'h9;
   localparam logic [7:0] IDLE_BYTE     = 8'hff;

   typedef logic [1:0] tsm_mode_t;
   typedef struct packed {
      logic [3:0] code;
      logic [7:0] data;
   } tsm_cm_t;
   typedef struct packed {
      logic [1:0] line;
      logic [4:0] slot;
      logic [7:0] data;
   } tsm_word_t;

   localparam tsm_cm_t CM_RESET_ENTRY = '{code: CM_UNASSIGNED, data: 8'h00};

   function automatic logic [4:0] blk_mask(tsm_mode_t m);
      return (m == 2'h0) ? 5'h01 : (m == 2'h1) ? 5'h03 : 5'h07;
   endfunction

   function automatic logic pcm_line_on(tsm_mode_t m, logic [1:0] l);
      return (m == 2'h0) ? 1'b1 : (m == 2'h1) ? !l[0] : (l == 2'h0);
   endfunction

   function automatic logic cfi_line_on(tsm_mode_t m, logic [1:0] l);
      return {1'b0, l} <= (3'h3 >> m);
   endfunction

   function automatic logic pcm_fetch_start(tsm_mode_t m, logic [4:0] s);
      return (m == 2'h0) ? !s[0] : (m == 2'h1) ? (s[1:0] == 2'h1) : (s[2:0] == 3'h3);
   endfunction

   function automatic logic pcm_read_skip(tsm_mode_t m, logic [4:0] s);
      return (m == 2'h0) ? s[0] : (m == 2'h1) ? (s[1:0] == 2'h2) : (s[2:0] == 3'h4);
   endfunction

   function automatic logic [4:0] pcm_ahead(tsm_mode_t m);
      return (m == 2'h0) ? PCM_AHEAD_M0 : (m == 2'h1) ? PCM_AHEAD_M1 : PCM_AHEAD_M2;
   endfunction

   // returns {line, slot} of the k-th word of a transmit fetch
   function automatic logic [6:0] pcm_fetch_addr(tsm_mode_t m, logic [4:0] b, logic [2:0] k);
      if (m == 2'h0) begin
         return {k[2], k[0], b + {4'h0, k[1]}};
      end else if (m == 2'h1) begin
         return {k[2], 1'b0, b + {3'h0, k[1:0]}};
      end
      return {2'h0, b + {2'h0, k}};
   endfunction

   function automatic logic [6:0] cfi_fetch_addr(logic [4:0] b, logic [2:0] k);
      return {k[2:1], b + {4'h0, k[0]}};
   endfunction

endpackage

// file: rtl/tsm_mem_if.sv
// port bundle between the access scheduler and one data memory half
// assumes a single clock; no timing inside the bundle
`timescale 1ns/100ps
interface tsm_mem_if;
   logic       we;
   logic [6:0] waddr;
   logic [7:0] wdata;
   logic       re;
   logic [6:0] raddr;
   logic [7:0] rdata;
   modport ctl (output we, waddr, wdata, re, raddr, input rdata);
   modport mem (input we, waddr, wdata, re, raddr, output rdata);
endinterface

// file: rtl/tsm_data_mem.sv
// one half of the switch data memory: 128 bytes, registered read
// assumes the scheduler never issues conflicting accesses
`timescale 1ns/100ps
module tsm_data_mem (
   // clock
   input wire logic clk_sys,
   // access port
   tsm_mem_if.mem   port
);
   logic [7:0] ram_q [128];

   always_ff @(posedge clk_sys) begin
      if (port.we) begin
         ram_q[port.waddr] <= port.wdata;
      end
      if (port.re) begin
         port.rdata <= ram_q[port.raddr];
      end
   end
endmodule // tsm_data_mem

// file: rtl/tsm_fifo.sv
// small synchronous fifo with registered room and empty flags
// assumes DEPTH is a power of two; a push while full is refused
`timescale 1ns/100ps
module tsm_fifo #(
   parameter int W     = 8,
   parameter int DEPTH = 16
) (
   // clock and reset
   input  wire logic         clk_sys,
   input  wire logic         rst,
   // fill side
   input  wire logic         in_valid,
   input  wire logic [W-1:0] in_data,
   output wire logic         in_ready,
   // drain side
   output wire logic         out_valid,
   output wire logic [W-1:0] out_data,
   input  wire logic         out_ready
);
   localparam int AW = $clog2(DEPTH);
   logic [W-1:0]  mem_q [DEPTH];
   logic [AW-1:0] wr_q, wr_d, rd_q, rd_d;
   logic [AW:0]   cnt_q, cnt_d;
   logic          room_q, room_d, empty_q, empty_d, push, pop;

   assign in_ready  = room_q;
   assign out_valid = !empty_q;
   assign out_data  = mem_q[rd_q];

   always_comb begin
      push    = in_valid && room_q;
      pop     = out_ready && !empty_q;
      wr_d    = push ? wr_q + 1'b1 : wr_q;
      rd_d    = pop ? rd_q + 1'b1 : rd_q;
      cnt_d   = cnt_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
      room_d  = (cnt_d != (AW+1)'(DEPTH));
      empty_d = (cnt_d == '0);
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         wr_q    <= '0;
         rd_q    <= '0;
         cnt_q   <= '0;
         room_q  <= 1'b1;
         empty_q <= 1'b1;
      end else begin
         wr_q    <= wr_d;
         rd_q    <= rd_d;
         cnt_q   <= cnt_d;
         room_q  <= room_d;
         empty_q <= empty_d;
      end
      if (push) begin
         mem_q[wr_q] <= in_data;
      end
   end
endmodule // tsm_fifo

// file: rtl/tsm_switch_timing.sv
// time-slot switch core: slot timing, data memory access schedule,
// connection control memory and preprocessed subscriber channels
// assumes all serial inputs are synchronous to clk_sys, one bit per
// reference clock period, msb first, frames of both sides aligned
//
// Function
// - deserialize before write, serialize after read
// - read after write gives zero frame delay
// - pcm receive writes commit per aligned block
// - pcm writes periods 0,4,7; skip block start
// - subscriber transmit fetched three slots ahead
// - subscriber fetch per line, even then odd
// - subscriber receive written from even slot, 1,3
// - pcm transmit fetched at mode-specific slots
// - upstream pcm skips period 0 at given slots
// - pcm transmit fetch runs in two steps
// - each subscriber slot switched or preprocessed
// - monitor handler buffers sixteen bytes each way
// - monitor handler serves one pointed slot only
// - command values via control memory, change reported
// - change means differs from previous frame
// - control memory reset marks slots unassigned
`timescale 1ns/100ps
module tsm_switch_timing
   import tsm_pkg::*;
(
   // clock and reset
   input  wire logic                 clk_sys,
   input  wire logic                 rst,
   // modes
   input  wire tsm_pkg::tsm_mode_t   pcm_mode,
   input  wire tsm_pkg::tsm_mode_t   cfi_mode,
   // pcm highway
   input  wire logic [3:0]           pcm_receive_line,
   output logic [3:0]                pcm_transmit_line_q,
   // subscriber side interface
   input  wire logic [3:0]           subscriber_upstream_line,
   output logic [3:0]                subscriber_downstream_line_q,
   // control memory programming
   input  wire logic                 cm_reset,
   input  wire logic                 cm_wr,
   input  wire logic [7:0]           cm_addr,
   input  wire tsm_pkg::tsm_cm_t     cm_wdata,
   // monitor/feature channel
   input  wire logic [6:0]           mf_slot,
   input  wire logic                 mf_tx_valid,
   input  wire logic [7:0]           mf_tx_data,
   output wire logic                 mf_tx_ready,
   output logic                      mf_rx_valid_q,
   output logic [7:0]                mf_rx_data_q,
   input  wire logic                 mf_rx_ready,
   // command/indication change report
   output logic                      ci_valid_q,
   output logic [6:0]                ci_addr_q,
   output logic [7:0]                ci_value_q
);
   import tsm_pkg::*;

   logic [5:0]  div_q, div_d;
   logic [2:0]  per_q, per_d, push_q, push_d;
   logic [4:0]  slot_q, slot_d, hold_slot_q, hold_slot_d;
   logic [7:0]  psh_q [4], psh_d [4], csh_q [4], csh_d [4];
   logic [7:0]  phold_q [4], phold_d [4], chold_q [4], chold_d [4];
   logic [7:0]  ptx_q [4], ptx_d [4], ctx_q [4], ctx_d [4];
   logic [7:0]  pbuf_q [32], pbuf_d [32], cbuf_q [16], cbuf_d [16];
   logic [4:0]  pcnt_q, pcnt_d, prel_q, prel_d, ccnt_q, ccnt_d, crel_q, crel_d;
   logic [3:0]  pk_q, pk_d, ck_q, ck_d, crd_idx_q, crd_idx_d;
   logic [4:0]  pbase_q, pbase_d, cbase_q, cbase_d, prd_idx_q, prd_idx_d;
   logic        prd_q, prd_d, crd_q, crd_d;
   tsm_cm_t     cm_q [256], cm_d [256];
   logic [3:0]  ptx_line_d, ctx_line_d;
   logic        rxv_d, ci_valid_d;
   logic [7:0]  rxd_d, ci_value_d;
   logic [6:0]  ci_addr_d;

   logic        tick, new_slot, pgrant, cwgrant, crgrant;
   logic [4:0]  ns;
   logic [2:0]  nact_p, nact_c;
   logic [6:0]  fa;
   tsm_cm_t     e;
   tsm_word_t   pwq_in, cwq_in, pwq_out, cwq_out;
   logic        pwq_iv, pwq_ov, pwq_or, cwq_iv, cwq_ov, cwq_or;
   logic        mtx_ov, mtx_or, mrx_iv, mrx_ir, mrx_ov, mrx_or;
   logic [7:0]  mtx_od, mrx_id, mrx_od;

   tsm_mem_if dn_if ();
   tsm_mem_if up_if ();

   // separate halves let the pcm write and the pcm read share periods 0,4,7
   tsm_data_mem u_dn_mem (.clk_sys(clk_sys), .port(dn_if.mem));
   tsm_data_mem u_up_mem (.clk_sys(clk_sys), .port(up_if.mem));

   tsm_fifo #(.W(15), .DEPTH(MF_DEPTH)) u_pcm_wq (
      .clk_sys(clk_sys), .rst(rst), .in_valid(pwq_iv), .in_data(pwq_in), .in_ready(),
      .out_valid(pwq_ov), .out_data(pwq_out), .out_ready(pwq_or));
   tsm_fifo #(.W(15), .DEPTH(MF_DEPTH)) u_cfi_wq (
      .clk_sys(clk_sys), .rst(rst), .in_valid(cwq_iv), .in_data(cwq_in), .in_ready(),
      .out_valid(cwq_ov), .out_data(cwq_out), .out_ready(cwq_or));
   tsm_fifo #(.W(8), .DEPTH(MF_DEPTH)) u_mf_tx (
      .clk_sys(clk_sys), .rst(rst), .in_valid(mf_tx_valid), .in_data(mf_tx_data),
      .in_ready(mf_tx_ready), .out_valid(mtx_ov), .out_data(mtx_od), .out_ready(mtx_or));
   tsm_fifo #(.W(8), .DEPTH(MF_DEPTH)) u_mf_rx (
      .clk_sys(clk_sys), .rst(rst), .in_valid(mrx_iv), .in_data(mrx_id), .in_ready(mrx_ir),
      .out_valid(mrx_ov), .out_data(mrx_od), .out_ready(mrx_or));

   always_comb begin
      div_d = div_q; per_d = per_q; slot_d = slot_q;
      psh_d = psh_q; csh_d = csh_q; phold_d = phold_q; chold_d = chold_q;
      ptx_d = ptx_q; ctx_d = ctx_q; pbuf_d = pbuf_q; cbuf_d = cbuf_q;
      hold_slot_d = hold_slot_q; push_d = push_q;
      pcnt_d = pcnt_q; prel_d = prel_q; ccnt_d = ccnt_q; crel_d = crel_q;
      pk_d = pk_q; ck_d = ck_q; pbase_d = pbase_q; cbase_d = cbase_q;
      prd_d = 1'b0; crd_d = 1'b0; prd_idx_d = prd_idx_q; crd_idx_d = crd_idx_q;
      cm_d = cm_q; ptx_line_d = pcm_transmit_line_q; ctx_line_d = subscriber_downstream_line_q;
      ci_valid_d = 1'b0; ci_addr_d = ci_addr_q; ci_value_d = ci_value_q;
      pwq_iv = 1'b0; cwq_iv = 1'b0; pwq_or = 1'b0; cwq_or = 1'b0;
      pwq_in = '0; cwq_in = '0; mtx_or = 1'b0; mrx_iv = 1'b0; mrx_id = 8'h00;
      dn_if.we = 1'b0; dn_if.waddr = 7'h00; dn_if.wdata = 8'h00;
      dn_if.re = 1'b0; dn_if.raddr = 7'h00;
      up_if.we = 1'b0; up_if.waddr = 7'h00; up_if.wdata = 8'h00;
      up_if.re = 1'b0; up_if.raddr = 7'h00;
      fa = 7'h00; e = CM_RESET_ENTRY;

      // reference clock as an enable; a granted period serves all its cycles, only the even ones for subscriber writes
      tick     = (div_q == RCL_DIV_LAST);
      div_d    = tick ? 6'h00 : div_q + 6'h01;
      new_slot = tick && (per_q == LAST_PER);
      ns       = slot_q + 5'h01;
      if (tick) begin
         per_d = per_q + 3'h1;
      end
      if (new_slot) begin
         slot_d = ns;
      end

      nact_p = 3'h0;
      nact_c = 3'h0;
      for (int l = 0; l < LINES; l++) begin
         nact_p = nact_p + {2'h0, pcm_line_on(pcm_mode, 2'(l))};
         nact_c = nact_c + {2'h0, cfi_line_on(cfi_mode, 2'(l))};
         if (tick) begin
            psh_d[l] = {psh_q[l][6:0], pcm_receive_line[l]};
            csh_d[l] = {csh_q[l][6:0], subscriber_upstream_line[l]};
            ptx_d[l] = {ptx_q[l][6:0], 1'b1};
            ctx_d[l] = {ctx_q[l][6:0], 1'b1};
         end
         if (new_slot) begin
            phold_d[l] = psh_d[l];
            chold_d[l] = csh_d[l];
            ptx_d[l]   = pbuf_q[{2'(l), ns[2:0]}];
            ctx_d[l]   = cbuf_q[{2'(l), ns[1:0]}];
         end
         ptx_line_d[l] = ptx_d[l][7];
         ctx_line_d[l] = ctx_d[l][7];
      end

      // completed words queue up, released only at block boundaries
      if (new_slot) begin
         hold_slot_d = slot_q;
         push_d      = 3'h0;
         if ((ns & blk_mask(pcm_mode)) == 5'h00) begin
            prel_d = prel_q + pcnt_q + {2'h0, nact_p};
            pcnt_d = 5'h00;
         end else begin
            pcnt_d = pcnt_q + {2'h0, nact_p};
         end
         if (!ns[0]) begin
            crel_d = crel_q + ccnt_q + {2'h0, nact_c};
            ccnt_d = 5'h00;
         end else begin
            ccnt_d = ccnt_q + {2'h0, nact_c};
         end
         if (pcm_fetch_start(pcm_mode, ns)) begin
            pk_d    = 4'h0;
            pbase_d = ns + pcm_ahead(pcm_mode);
         end
         if (ns[0]) begin
            ck_d    = 4'h0;
            cbase_d = ns + CFI_AHEAD;
         end
      end else if (push_q != PUSH_DONE) begin
         pwq_iv = pcm_line_on(pcm_mode, push_q[1:0]);
         cwq_iv = cfi_line_on(cfi_mode, push_q[1:0]);
         pwq_in = '{line: push_q[1:0], slot: hold_slot_q, data: phold_q[push_q[1:0]]};
         cwq_in = '{line: push_q[1:0], slot: hold_slot_q, data: chold_q[push_q[1:0]]};
         push_d = push_q + 3'h1;
      end

      // one port per period on each half: pcm 0,4,7; subscriber 1,3 and 5,6
      // odd cycles skipped on subscriber writes so change pulses never merge
      pgrant  = (per_q == PCM_PER_A || per_q == PCM_PER_B || per_q == PCM_PER_C);
      cwgrant = !div_q[0] && (per_q == CFI_WR_A || per_q == CFI_WR_B);
      crgrant = (per_q == CFI_RD_A || per_q == CFI_RD_B);

      // a read placed after the write in the frame sees this frame's word
      if (pgrant && prel_q != 5'h00 && pwq_ov &&
          !(per_q == PCM_PER_A && (slot_q & blk_mask(pcm_mode)) == 5'h00)) begin
         pwq_or      = 1'b1;
         prel_d      = prel_q - 5'h01;
         dn_if.we    = 1'b1;
         dn_if.waddr = {pwq_out.line, pwq_out.slot};
         dn_if.wdata = pwq_out.data;
      end

      if (pgrant && pk_q != FETCH_DONE &&
          !(per_q == PCM_PER_A && pcm_read_skip(pcm_mode, slot_q))) begin
         fa        = pcm_fetch_addr(pcm_mode, pbase_q, pk_q[2:0]);
         up_if.re  = 1'b1;
         up_if.raddr = fa;
         prd_d     = 1'b1;
         prd_idx_d = {fa[6:5], fa[2:0]};
         pk_d      = pk_q + 4'h1;
      end
      if (prd_q) begin
         pbuf_d[prd_idx_q] = up_if.rdata;
      end

      if (cwgrant && crel_q != 5'h00 && cwq_ov) begin
         cwq_or = 1'b1;
         crel_d = crel_q - 5'h01;
         e      = cm_q[{1'b1, cwq_out.line, cwq_out.slot}];
         case (e.code)
            CM_SWITCH: begin
               up_if.we    = 1'b1;
               up_if.waddr = e.data[6:0];
               up_if.wdata = cwq_out.data;
            end
            CM_CS: begin
               if (cwq_out.data != e.data) begin
                  cm_d[{1'b1, cwq_out.line, cwq_out.slot}].data = cwq_out.data;
                  ci_valid_d = 1'b1;
                  ci_addr_d  = {cwq_out.line, cwq_out.slot};
                  ci_value_d = cwq_out.data;
               end
            end
            CM_MF: begin
               // a full receive buffer drops the byte, software must keep up
               if ({cwq_out.line, cwq_out.slot} == mf_slot) begin
                  mrx_iv = 1'b1;
                  mrx_id = cwq_out.data;
               end
            end
            default: begin
            end
         endcase
      end

      // a whole fetch fits into period 5, so no word waits for the next slot
      if (crgrant && ck_q < (FETCH_DONE >> cfi_mode)) begin
         fa        = cfi_fetch_addr(cbase_q, ck_q[2:0]);
         e         = cm_q[{1'b0, fa}];
         crd_idx_d = {fa[6:5], fa[1:0]};
         ck_d      = ck_q + 4'h1;
         cbuf_d[crd_idx_d] = IDLE_BYTE;
         case (e.code)
            CM_SWITCH: begin
               dn_if.re    = 1'b1;
               dn_if.raddr = e.data[6:0];
               crd_d       = 1'b1;
            end
            CM_CS: begin
               cbuf_d[crd_idx_d] = e.data;
            end
            CM_MF: begin
               if (fa == mf_slot && mtx_ov) begin
                  mtx_or = 1'b1;
                  cbuf_d[crd_idx_d] = mtx_od;
               end
            end
            default: begin
            end
         endcase
      end
      if (crd_q) begin
         cbuf_d[crd_idx_q] = dn_if.rdata;
      end

      if (cm_wr) begin
         cm_d[cm_addr] = cm_wdata;
      end
      if (cm_reset) begin
         for (int i = 0; i < 256; i++) begin
            cm_d[i] = CM_RESET_ENTRY;
         end
      end

      mrx_or = !mf_rx_valid_q || mf_rx_ready;
      rxv_d  = mrx_or ? mrx_ov : mf_rx_valid_q;
      rxd_d  = (mrx_or && mrx_ov) ? mrx_od : mf_rx_data_q;
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         div_q <= 6'h00; per_q <= 3'h0; slot_q <= 5'h00;
         hold_slot_q <= 5'h00; push_q <= PUSH_DONE;
         pcnt_q <= 5'h00; prel_q <= 5'h00; ccnt_q <= 5'h00; crel_q <= 5'h00;
         pk_q <= FETCH_DONE; ck_q <= FETCH_DONE; pbase_q <= 5'h00; cbase_q <= 5'h00;
         prd_q <= 1'b0; crd_q <= 1'b0; prd_idx_q <= 5'h00; crd_idx_q <= 4'h0;
         pcm_transmit_line_q <= 4'hf; subscriber_downstream_line_q <= 4'hf;
         mf_rx_valid_q <= 1'b0; mf_rx_data_q <= 8'h00;
         ci_valid_q <= 1'b0; ci_addr_q <= 7'h00; ci_value_q <= 8'h00;
         for (int l = 0; l < LINES; l++) begin
            psh_q[l] <= 8'h00; csh_q[l] <= 8'h00; phold_q[l] <= 8'h00;
            chold_q[l] <= 8'h00; ptx_q[l] <= IDLE_BYTE; ctx_q[l] <= IDLE_BYTE;
         end
         for (int i = 0; i < 32; i++) begin
            pbuf_q[i] <= IDLE_BYTE;
         end
         for (int i = 0; i < 16; i++) begin
            cbuf_q[i] <= IDLE_BYTE;
         end
         for (int i = 0; i < 256; i++) begin
            cm_q[i] <= CM_RESET_ENTRY;
         end
      end else begin
         div_q <= div_d; per_q <= per_d; slot_q <= slot_d;
         hold_slot_q <= hold_slot_d; push_q <= push_d;
         pcnt_q <= pcnt_d; prel_q <= prel_d; ccnt_q <= ccnt_d; crel_q <= crel_d;
         pk_q <= pk_d; ck_q <= ck_d; pbase_q <= pbase_d; cbase_q <= cbase_d;
         prd_q <= prd_d; crd_q <= crd_d; prd_idx_q <= prd_idx_d; crd_idx_q <= crd_idx_d;
         pcm_transmit_line_q <= ptx_line_d; subscriber_downstream_line_q <= ctx_line_d;
         mf_rx_valid_q <= rxv_d; mf_rx_data_q <= rxd_d;
         ci_valid_q <= ci_valid_d; ci_addr_q <= ci_addr_d; ci_value_q <= ci_value_d;
         psh_q <= psh_d; csh_q <= csh_d; phold_q <= phold_d; chold_q <= chold_d;
         ptx_q <= ptx_d; ctx_q <= ctx_d; pbuf_q <= pbuf_d; cbuf_q <= cbuf_d;
         cm_q <= cm_d;
      end
   end
endmodule // tsm_switch_timing

// file: tb/tsm_far_side.sv
// far side model: pcm highway and subscriber devices sending per-slot bytes, frame-dependent in pcm slot 0 and subscriber slots 4, 7
// assumes cyc counts clk_sys cycles from reset release, 48 per bit
`timescale 1ns/100ps
module tsm_far_side (
   // position
   input  wire logic        clk_sys,
   input  wire logic [31:0] cyc,
   // serial lines into the switch
   output logic [3:0]       pcm_receive_line,
   output logic [3:0]       subscriber_upstream_line
);
   int         g;
   int         fr;
   int         sl;
   logic [7:0] pb;
   logic [7:0] sb;
   always @(negedge clk_sys) begin
      // bit window centred on the sampling tick, so a one-cycle skew is harmless
      g = (int'(cyc) + 24) / 48 - 1; // bit shift never moves
      fr = g / 256;
      sl = (g / 8) % 32;
      pb = (sl == 0) ? 8'h30 + 8'(fr) : 8'ha5 ^ 8'(sl);
      sb = (sl == 4) ? 8'h40 + 8'(fr) : (sl == 6) ? 8'h66 : 8'h5a ^ 8'(sl);
      if (sl == 7) begin
         sb = (fr < 2) ? 8'h11 : 8'h22;
      end
      pcm_receive_line <= (g < 0) ? 4'hf : {4{pb[7 - g % 8]}};
      subscriber_upstream_line <= (g < 0) ? 4'hf : {4{sb[7 - g % 8]}};
   end
endmodule // tsm_far_side

// file: tb/tsm_switch_timing_asserts.sv
// checker for the slot switch core: bit spacing, handshakes, reset
// assumes it is bound to tsm_switch_timing and sees only its ports
`timescale 1ns/100ps
module tsm_switch_timing_asserts
   import tsm_pkg::*;
(
   // clock, reset, control memory
   input wire logic             clk_sys,
   input wire logic             rst,
   input wire logic             cm_reset,
   input wire logic             cm_wr,
   input wire logic [7:0]       cm_addr,
   input wire tsm_pkg::tsm_cm_t cm_wdata,
   // outputs and handshakes
   input wire logic [3:0]       pcm_transmit_line_q,
   input wire logic [3:0]       subscriber_downstream_line_q,
   input wire logic             mf_tx_valid,
   input wire logic             mf_tx_ready,
   input wire logic             mf_rx_valid_q,
   input wire logic [7:0]       mf_rx_data_q,
   input wire logic             mf_rx_ready,
   input wire logic             ci_valid_q,
   input wire logic [7:0]       ci_value_q
);
   localparam int SPAN = 24576;
   wire  [7:0]  outs = {pcm_transmit_line_q, subscriber_downstream_line_q};
   logic [7:0]  prev_q, prev_d;
   logic [5:0]  gap_q, gap_d;
   logic        seen_q, seen_d;
   logic        prog_q, prog_d;
   logic [15:0] idle_q, idle_d;
   always_comb begin
      prev_d = outs;
      gap_d = (outs != prev_q || gap_q == 6'h2f) ? 6'h00 : gap_q + 6'h01;
      seen_d = seen_q | (outs != prev_q);
      prog_d = !cm_reset & (prog_q | (cm_wr & !cm_addr[7] & (cm_wdata.code != CM_UNASSIGNED)));
      // two frames flush every fetched word
      idle_d = (cm_reset | prog_q) ? 16'h0000 : (idle_q == 16'(SPAN)) ? idle_q : idle_q + 16'h0001;
   end
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         prev_q <= 8'hff;
         gap_q <= 6'h00;
         seen_q <= 1'b0;
         prog_q <= 1'b0;
         idle_q <= 16'h0000;
      end else begin
         prev_q <= prev_d;
         gap_q <= gap_d;
         seen_q <= seen_d;
         prog_q <= prog_d;
         idle_q <= idle_d;
      end
   end
   default clocking @(posedge clk_sys); endclocking
   default disable iff (rst);
   sequence rx_wait; mf_rx_valid_q && !mf_rx_ready; endsequence
   sequence rx_kept; mf_rx_valid_q && $stable(mf_rx_data_q); endsequence
   reset_idle_a: assert property (disable iff (1'b0) rst |=> outs == 8'hff)
      else $error("outputs not idle");
   reset_quiet_a: assert property (disable iff (1'b0) rst |=> !mf_rx_valid_q && !ci_valid_q && mf_tx_ready)
      else $error("flags wrong after reset");
   bit_spacing_a: assert property (outs != prev_q && seen_q |-> gap_q == 6'h2f)
      else $error("serial bit not 48 cycles");
   ci_pulse_a: assert property (ci_valid_q |=> !ci_valid_q)
      else $error("change pulse too long");
   ci_value_a: assert property ($changed(ci_value_q) |-> ci_valid_q)
      else $error("value moved without pulse");
   rx_hold_a: assert property (rx_wait |=> rx_kept)
      else $error("rx byte not held");
   tx_full_a: assert property ($fell(mf_tx_ready) |-> $past(mf_tx_valid))
      else $error("full without push");
   clear_idle_a: assert property (!prog_q && idle_q == 16'(SPAN) |-> subscriber_downstream_line_q == 4'hf)
      else $error("unassigned slot not idle");
endmodule // tsm_switch_timing_asserts
bind tsm_switch_timing tsm_switch_timing_asserts i_chk (.clk_sys, .rst, .cm_reset, .cm_wr, .cm_addr, .cm_wdata,
   .pcm_transmit_line_q, .subscriber_downstream_line_q, .mf_tx_valid, .mf_tx_ready, .mf_rx_valid_q,
   .mf_rx_data_q, .mf_rx_ready, .ci_valid_q, .ci_value_q);

// file: tb/testbench.sv
// bench for the slot switch core, pcm and subscriber mode 0
// assumes the far side model aligns its bytes to reset release
`timescale 1ns/100ps
module testbench;
   import tsm_pkg::*;
   logic        clk_sys = 0, rst = 1, cm_reset = 0, cm_wr = 0, mf_tx_valid = 0, mf_rx_ready = 0;
   logic [7:0]  cm_addr = 0, mf_tx_data = 0, mf_rx_data_q, ci_value_q;
   tsm_cm_t     cm_wdata = 0;
   logic [3:0]  pcm_receive_line, pcm_transmit_line_q, subscriber_upstream_line, subscriber_downstream_line_q;
   logic        mf_tx_ready, mf_rx_valid_q, ci_valid_q;
   logic [6:0]  ci_addr_q;
   logic [31:0] cyc = 0;
   logic [14:0] ci_q[$];
   logic [7:0]  rx_q[$];
   int          miscompares = 0, tests_run = 0;
   always #5 clk_sys = ~clk_sys;
   always @(posedge clk_sys)
      cyc <= rst ? 0 : cyc + 1;
   always @(negedge clk_sys) begin
      if (ci_valid_q === 1'b1)
         ci_q.push_back({ci_addr_q, ci_value_q});
      if (mf_rx_valid_q === 1'b1 && mf_rx_ready)
         rx_q.push_back(mf_rx_data_q);
   end
   tsm_far_side i_far (.clk_sys, .cyc, .pcm_receive_line, .subscriber_upstream_line);
   tsm_switch_timing i_dut (.clk_sys, .rst, .pcm_mode(2'h0), .cfi_mode(2'h0), .pcm_receive_line, .pcm_transmit_line_q,
      .subscriber_upstream_line, .subscriber_downstream_line_q, .cm_reset, .cm_wr, .cm_addr, .cm_wdata,
      .mf_slot(7'h06), .mf_tx_valid, .mf_tx_data, .mf_tx_ready, .mf_rx_valid_q, .mf_rx_data_q, .mf_rx_ready,
      .ci_valid_q, .ci_addr_q, .ci_value_q);
   task automatic check(input logic [15:0] got, exp);
      tests_run++;
      if (got !== exp) begin
         miscompares++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // collects the byte of one line and slot in a given frame
   task automatic grab(input int ln, fr, sl, bit pcm, output logic [7:0] b);
      for (int p = 0; p < 8; p++) begin
         while (int'(cyc) < 48 * (fr * 256 + sl * 8 + p) + 24) @(negedge clk_sys);
         b[7 - p] = pcm ? pcm_transmit_line_q[ln] : subscriber_downstream_line_q[ln];
      end
   endtask
   task automatic cm(input logic [7:0] a, input logic [3:0] c, input logic [7:0] d);
      @(negedge clk_sys);
      cm_wr = 1;
      cm_addr = a;
      cm_wdata = '{code: c, data: d};
      @(negedge clk_sys);
      cm_wr = 0;
   endtask
   task automatic t_delay;
      logic [7:0] b;
      grab(1, 2, 2, 0, b);
      check(16'(b), 16'h31);
      grab(1, 2, 10, 0, b);
      check(16'(b), 16'h32);
      grab(1, 2, 20, 1, b);
      check(16'(b), 16'h42);
      $display("delay test done");
   endtask
   task automatic t_mf;
      logic [7:0] b;
      int         n = 0;
      grab(0, 3, 0, 0, b);
      mf_rx_ready = 1;
      for (int i = 0; i < 17; i++) begin
         mf_tx_valid = 1;
         mf_tx_data = 8'hc0 + 8'(i);
         n += (mf_tx_ready === 1'b1);
         @(negedge clk_sys);
      end
      mf_tx_valid = 0;
      check(16'(n), 16'h10);
      grab(0, 3, 6, 0, b);
      check(16'(b), 16'hc0);
      grab(0, 4, 6, 0, b);
      check(16'(b), 16'hc1);
      check(16'(rx_q[0]), 16'h66);
      check(16'(ci_q.size()), 16'h2);
      check(16'(ci_q[0]), 16'h0711);
      check(16'(ci_q[1]), 16'h0722);
      $display("preprocessed test done");
   endtask
   task automatic t_clear;
      logic [7:0] b;
      cm_reset = 1;
      @(negedge clk_sys);
      cm_reset = 0;
      grab(1, 7, 10, 0, b);
      check(16'(b), 16'hff);
      $display("clear test done");
   endtask
   task automatic report_and_stop;
      $display("comparisons %0d mismatches %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   initial begin
      repeat (12) @(negedge clk_sys);
      rst = 0;
      cm(8'h22, CM_SWITCH, 8'h00);
      cm(8'h2a, CM_SWITCH, 8'h00);
      cm(8'h84, CM_SWITCH, 8'h34);
      cm(8'h06, CM_MF, 8'h00);
      cm(8'h86, CM_MF, 8'h00);
      cm(8'h87, CM_CS, 8'h00);
      t_delay;
      t_mf;
      t_clear;
      report_and_stop;
   end
   initial begin
      repeat (95000) @(posedge clk_sys);
      miscompares++;
      report_and_stop;
   end
endmodule // testbench
